// [station_link_cfg.svh]
// station link sequencer constants: register offsets, fields, resets, timing
// assumes inclusion by bare name from the design module and the testbench
`ifndef STATION_LINK_CFG_SVH
`define STATION_LINK_CFG_SVH
`define SL_CTRL_OFF      12'h000
`define SL_TIMEOUT_OFF   12'h004
`define SL_CALL_OFF      12'h008
`define SL_WIN1_OFF      12'h00c
`define SL_WIN2_OFF      12'h010
`define SL_RTC_OFF       12'h014
`define SL_STATUS_OFF    12'h018
`define SL_ERROR_OFF     12'h01c
`define SL_CMD_OFF       12'h020
`define SL_ACTION_OFF    12'h024
`define SL_INPUT_OFF     12'h028
`define SL_MODEM_OFF     12'h02c
`define SL_PWCHK_OFF     12'h030
`define SL_PWSET_OFF     12'h034
`define SL_CSUM_OFF      12'h038
`define SL_ACCESS_OFF    12'h03c
`define SL_CLK_HZ        40000000
`define SL_TICK_S        1
`define SL_TICK_CYC      (`SL_CLK_HZ * `SL_TICK_S)
`define SL_ATTEMPT_RST   8'h03
`define SL_CYCLE_WAIT_RST 8'h1e
`define SL_MODEM_ADDR_RST 16'h03f8
`define SL_DIAL_PULSE    8'h50
`define SL_DIAL_TONE     8'h54
`define SL_DAY_CAP       4'ha
`define SL_ERR_CLEAR     8'h00
`define SL_ACCESS_CODE   32'h0000a5a5
`endif

// [station_link_pkg.sv]
// types for the station link call sequencer
// needs nothing from the cfg header
package station_link_pkg;
   typedef enum logic [2:0] {CALL_IDLE, CALL_A1, CALL_A2, CALL_WAIT, CALL_DONE} call_state_t;
   typedef enum logic [1:0] {LVL_LOW, LVL_UNDEFINED_INPUT_LEVEL, LVL_HIGH, LVL_BREAK} level_t;
endpackage

// [station_link_call_sequencer.sv]
// station link call sequencer: modem link supervision, call answer, spontaneous calls
// assumes an apb master on clk, firmware reporting call results, pins unsynchronised
`include "station_link_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module station_link_call_sequencer
   import station_link_pkg::*;
#(
   parameter int TICK_CYC = `SL_TICK_CYC
)(
   input wire logic clk,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic modem_enable_switch,
   input wire logic ring_in,
   input wire logic rx_char,
   input wire logic tx_char,
   input wire logic block_sent,
   input wire logic reply_rx,
   input wire logic link_up,
   input wire logic fault_valid,
   input wire logic [7:0] fault_code,
   input wire logic [3:0] input_event,
   input wire logic call_ok,
   input wire logic call_fail,
   input wire logic minute_in_day_tick,
   input wire logic [10:0] clock_minute,
   input wire logic mon_char_valid,
   input wire logic [7:0] mon_char,
   output logic off_hook,
   output logic hang_up,
   output logic reply_timeout,
   output logic call_req,
   output logic [2:0] call_action,
   output logic rtc_adjust,
   output logic rtc_adjust_up,
   output logic modem_char_valid,
   output logic [7:0] modem_char,
   output logic [1:0] level_class
);
   // synchronised pins
   logic [1:0] ring_sync_reg, sw_sync_reg;
   logic ring_d_reg;
   logic [7:0] lvl_sync1_reg, lvl_sync2_reg;
   // registers
   logic [31:0] ctrl_reg, tmo_reg, call_reg, win1_reg, win2_reg, modem_reg, input_reg;
   logic [31:0] action_reg [0:3];
   logic [31:0] pw_reg [0:3];
   logic [15:0] rtc_corr_reg;
   logic [7:0] error_reg;
   logic authed_reg, unlocked_reg;
   logic [31:0] csum_reg;
   logic [26:0] tick_cnt_reg;
   logic sec_tick_reg;
   logic [5:0] wait_sec_reg;
   logic [7:0] gap_reg, resp_reg, inact_reg;
   logic [5:0] inact_sec_reg;
   logic resp_run_reg;
   logic [3:0] ring_cnt_reg;
   logic [15:0] corr_cnt_reg;
   call_state_t call_state_reg;
   logic [7:0] tries_reg, wait_reg;
   logic second_cycle_reg;
   logic [1:0] cur_input_reg;
   logic [3:0] day_cnt_reg [0:3];
   logic wr_en, rd_en, par_wr;
   logic [1:0] widx;
   logic win_ok;

   // window compare: start minute in [26:16], end minute in [10:0], bit 31 enables
   function automatic logic in_window(input logic [31:0] w, input logic [10:0] m);
      in_window = w[31] && (m >= w[26:16]) && (m < w[10:0]);
   endfunction

   // two-level mode merges pairs
   function automatic logic [1:0] classify(input logic [1:0] raw, input logic four);
      classify = four ? raw : {raw[1], 1'b0};
   endfunction

   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && penable && !pwrite;
   assign par_wr = wr_en && unlocked_reg;
   assign widx = pwdata[29:28];
   assign win_ok = (!win1_reg[31] && !win2_reg[31]) ||
                   in_window(win1_reg, clock_minute) || in_window(win2_reg, clock_minute);

   // pin synchronisers
   always_ff @(posedge clk)
   begin
      ring_sync_reg <= {ring_sync_reg[0], ring_in};
      sw_sync_reg <= {sw_sync_reg[0], modem_enable_switch};
      lvl_sync1_reg <= {4'h0, input_event};
      lvl_sync2_reg <= lvl_sync1_reg;
      ring_d_reg <= ring_sync_reg[1];
   end

   // one second tick
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         tick_cnt_reg <= 27'h0;
         sec_tick_reg <= 1'b0;
      end
      else
      begin
         sec_tick_reg <= (tick_cnt_reg == 27'(TICK_CYC - 1));
         tick_cnt_reg <= (tick_cnt_reg == 27'(TICK_CYC - 1)) ? 27'h0 : tick_cnt_reg + 27'h1;
      end
   end

   // configuration registers; ctrl: [0] tone dial, [1] four levels, [2] passthrough
   always_ff @(posedge clk)
   begin
      if (srst || (wr_en && paddr == `SL_CSUM_OFF && pwdata != csum_reg))
      begin
         ctrl_reg <= 32'h0;
         tmo_reg <= 32'h000a0a05;
         call_reg <= {16'h0, `SL_CYCLE_WAIT_RST, `SL_ATTEMPT_RST} | 32'h00020000;
         win1_reg <= 32'h0;
         win2_reg <= 32'h0;
         rtc_corr_reg <= 16'h0;
         modem_reg <= {16'h0, `SL_MODEM_ADDR_RST};
         input_reg <= 32'h0;
      end
      else if (par_wr)
      begin
         if (paddr == `SL_CTRL_OFF)
            ctrl_reg <= pwdata;
         else if (paddr == `SL_TIMEOUT_OFF)
            tmo_reg <= pwdata;
         else if (paddr == `SL_CALL_OFF)
            call_reg <= pwdata;
         else if (paddr == `SL_WIN1_OFF)
            win1_reg <= pwdata;
         else if (paddr == `SL_WIN2_OFF)
            win2_reg <= pwdata;
         else if (paddr == `SL_RTC_OFF)
            rtc_corr_reg <= pwdata[15:0];
         else if (paddr == `SL_MODEM_OFF)
            modem_reg <= pwdata;
         else if (paddr == `SL_INPUT_OFF)
            input_reg <= {pwdata[31:24] & 8'h77, pwdata[23:0]};
      end
   end

   // actions and passwords, index in [29:28]
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         for (int i = 0; i < 4; i++)
         begin
            action_reg[i] <= 32'h0;
            pw_reg[i] <= 32'(i + 1);
         end
      end
      else if (par_wr && paddr == `SL_ACTION_OFF)
         action_reg[widx] <= {pwdata[31:28], pwdata[27:0]};
      else if (par_wr && paddr == `SL_PWSET_OFF)
         pw_reg[widx] <= {4'h0, pwdata[27:0]};
   end

   // station authorisation and access code lock
   always_ff @(posedge clk)
   begin
      if (srst || !link_up)
         authed_reg <= 1'b0;
      else if (wr_en && paddr == `SL_PWCHK_OFF)
         authed_reg <= (pw_reg[widx] == {4'h0, pwdata[27:0]});
   end
   always_ff @(posedge clk)
   begin
      if (srst)
         unlocked_reg <= 1'b0;
      else if (wr_en && paddr == `SL_ACCESS_OFF)
         unlocked_reg <= (pwdata == `SL_ACCESS_CODE);
      else if (wr_en && paddr == `SL_CMD_OFF && pwdata[1])
         unlocked_reg <= 1'b0;
   end
   always_ff @(posedge clk)
   begin
      if (srst)
         csum_reg <= 32'h0;
      else if (par_wr && paddr != `SL_CSUM_OFF)
         csum_reg <= csum_reg + pwdata;
   end

   // sticky error status; a fault in the clearing cycle wins
   always_ff @(posedge clk)
   begin
      if (srst)
         error_reg <= `SL_ERR_CLEAR;
      else if (fault_valid)
         error_reg <= fault_code;
      else if (wr_en && paddr == `SL_CMD_OFF && pwdata[0])
         error_reg <= `SL_ERR_CLEAR;
   end

   // link timeouts: gap, reply, inactivity
   always_ff @(posedge clk)
   begin
      if (srst || !link_up)
      begin
         gap_reg <= 8'h0;
         resp_reg <= 8'h0;
         resp_run_reg <= 1'b0;
         inact_reg <= 8'h0;
         inact_sec_reg <= 6'h0;
         hang_up <= 1'b0;
         reply_timeout <= 1'b0;
      end
      else
      begin
         hang_up <= 1'b0;
         reply_timeout <= 1'b0;
         if (rx_char)
            gap_reg <= 8'h0;
         else if (sec_tick_reg)
            gap_reg <= gap_reg + 8'h1;
         if (!rx_char && sec_tick_reg && gap_reg + 8'h1 > tmo_reg[7:0] && tmo_reg[7:0] != 8'h0)
            hang_up <= 1'b1;
         if (block_sent)
         begin
            resp_run_reg <= 1'b1;
            resp_reg <= 8'h0;
         end
         else if (reply_rx)
            resp_run_reg <= 1'b0;
         else if (resp_run_reg && sec_tick_reg)
         begin
            resp_reg <= resp_reg + 8'h1;
            if (resp_reg + 8'h1 >= tmo_reg[15:8])
            begin
               reply_timeout <= 1'b1;
               resp_run_reg <= 1'b0;
            end
         end
         if (rx_char || tx_char)
         begin
            inact_reg <= 8'h0;
            inact_sec_reg <= 6'h0;
         end
         else if (sec_tick_reg && inact_sec_reg != 6'h3b)
            inact_sec_reg <= inact_sec_reg + 6'h1;
         else if (sec_tick_reg) // a whole idle minute has passed
         begin
            inact_sec_reg <= 6'h0;
            inact_reg <= inact_reg + 8'h1;
            if (inact_reg + 8'h1 >= tmo_reg[23:16])
               hang_up <= 1'b1;
         end
      end
   end

   // ring counting and off-hook
   always_ff @(posedge clk)
   begin
      if (srst || link_up || !sw_sync_reg[1])
      begin
         ring_cnt_reg <= 4'h0;
         off_hook <= 1'b0;
      end
      else if (ring_sync_reg[1] && !ring_d_reg && win_ok)
      begin
         ring_cnt_reg <= ring_cnt_reg + 4'h1;
         if (ring_cnt_reg + 4'h1 >= call_reg[19:16])
            off_hook <= 1'b1;
      end
   end

   // clock correction
   always_ff @(posedge clk)
   begin
      if (srst || rtc_corr_reg == 16'h0)
      begin
         corr_cnt_reg <= 16'h0;
         rtc_adjust <= 1'b0;
         rtc_adjust_up <= 1'b0;
      end
      else
      begin
         rtc_adjust <= 1'b0;
         rtc_adjust_up <= !rtc_corr_reg[15];
         if (sec_tick_reg)
         begin
            if (corr_cnt_reg + 16'h1 >= (rtc_corr_reg[15] ? 16'(-rtc_corr_reg) : rtc_corr_reg))
            begin
               corr_cnt_reg <= 16'h0;
               rtc_adjust <= 1'b1;
            end
            else
               corr_cnt_reg <= corr_cnt_reg + 16'h1;
         end
      end
   end

   // spontaneous call sequence; input_reg[31:24] holds slots (4 inputs share)
   always_ff @(posedge clk)
   begin
      if (srst || !sw_sync_reg[1])
      begin
         call_state_reg <= CALL_IDLE;
         tries_reg <= 8'h0;
         wait_reg <= 8'h0;
         wait_sec_reg <= 6'h0;
         second_cycle_reg <= 1'b0;
         call_req <= 1'b0;
         call_action <= 3'h0;
         cur_input_reg <= 2'h0;
      end
      else
      begin
         call_req <= 1'b0;
         case (call_state_reg)
            CALL_IDLE:
               for (int i = 3; i >= 0; i--)
                  if (lvl_sync2_reg[i] && day_cnt_reg[i] < `SL_DAY_CAP && input_reg[26:24] != 3'h0)
                  begin
                     call_state_reg <= CALL_A1;
                     cur_input_reg <= 2'(i);
                     call_action <= input_reg[26:24];
                     call_req <= 1'b1;
                     tries_reg <= 8'h1;
                     second_cycle_reg <= 1'b0;
                  end
            CALL_A1, CALL_A2:
               if (call_ok)
                  call_state_reg <= CALL_DONE;
               else if (call_fail)
               begin
                  if (tries_reg < call_reg[7:0])
                  begin
                     tries_reg <= tries_reg + 8'h1;
                     call_req <= 1'b1;
                  end
                  else if (call_state_reg == CALL_A1 && input_reg[30:28] != 3'h0)
                  begin
                     call_state_reg <= CALL_A2;
                     call_action <= input_reg[30:28];
                     tries_reg <= 8'h1;
                     call_req <= 1'b1;
                  end
                  else if (!second_cycle_reg)
                  begin
                     call_state_reg <= CALL_WAIT;
                     wait_reg <= 8'h0;
                     wait_sec_reg <= 6'h0;
                  end
                  else
                     call_state_reg <= CALL_DONE;
               end
            CALL_WAIT:
               if (sec_tick_reg && wait_sec_reg != 6'h3b)
                  wait_sec_reg <= wait_sec_reg + 6'h1;
               else if (sec_tick_reg) // a whole minute of waiting has passed
               begin
                  wait_sec_reg <= 6'h0;
                  wait_reg <= wait_reg + 8'h1;
                  if (wait_reg + 8'h1 >= call_reg[15:8])
                  begin
                     call_state_reg <= CALL_A1;
                     second_cycle_reg <= 1'b1;
                     call_action <= input_reg[26:24];
                     tries_reg <= 8'h1;
                     call_req <= 1'b1;
                  end
               end
            default:
               call_state_reg <= CALL_IDLE;
         endcase
      end
   end

   // per-input daily message counters
   always_ff @(posedge clk)
   begin
      for (int i = 0; i < 4; i++)
         if (srst || minute_in_day_tick || (wr_en && paddr == `SL_CMD_OFF && pwdata[2]))
            day_cnt_reg[i] <= 4'h0;
         else if (call_req && call_state_reg == CALL_A1 && tries_reg == 8'h1 &&
                  !second_cycle_reg && i == 32'(cur_input_reg) && day_cnt_reg[i] < `SL_DAY_CAP)
            day_cnt_reg[i] <= day_cnt_reg[i] + 4'h1;
   end

   // monitor passthrough and level class
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         modem_char_valid <= 1'b0;
         modem_char <= 8'h0;
         level_class <= 2'h0;
      end
      else
      begin
         modem_char_valid <= mon_char_valid && ctrl_reg[2] && sw_sync_reg[1];
         modem_char <= mon_char;
         level_class <= classify(input_reg[1:0], ctrl_reg[1]);
      end
   end

   // apb slave: answer in the access cycle, unmapped reads zero, no error
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         prdata <= 32'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= psel && !penable;
         pslverr <= 1'b0;
         if (psel && !penable && !pwrite)
         begin
            if (!authed_reg && !unlocked_reg && paddr != `SL_STATUS_OFF)
               prdata <= 32'h0;
            else if (paddr == `SL_CTRL_OFF)
               prdata <= ctrl_reg;
            else if (paddr == `SL_TIMEOUT_OFF)
               prdata <= tmo_reg;
            else if (paddr == `SL_CALL_OFF)
               prdata <= call_reg;
            else if (paddr == `SL_MODEM_OFF)
               prdata <= modem_reg;
            else if (paddr == `SL_ERROR_OFF)
               prdata <= {24'h0, error_reg};
            else if (paddr == `SL_STATUS_OFF)
               prdata <= {21'h0, unlocked_reg, authed_reg, second_cycle_reg,
                          ctrl_reg[0] ? `SL_DIAL_TONE : `SL_DIAL_PULSE};
            else
               prdata <= 32'h0;
         end
      end
   end
endmodule
`default_nettype wire

// [station_link_call_sequencer_chk_asserts.sv]
// checker for the station link call sequencer, watching top ports only
// assumes clk rising edge sampling and srst synchronous active high
`timescale 1ns/1ps
`default_nettype none
module station_link_call_sequencer_chk #(
   parameter int TICK_CYC = 8
)(
   input wire logic clk,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic modem_enable_switch,
   input wire logic off_hook,
   input wire logic hang_up,
   input wire logic reply_timeout,
   input wire logic call_req,
   input wire logic [2:0] call_action,
   input wire logic rtc_adjust,
   input wire logic rtc_adjust_up,
   input wire logic mon_char_valid,
   input wire logic [7:0] mon_char,
   input wire logic modem_char_valid,
   input wire logic [7:0] modem_char
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (srst);
   // bus handshake: answer in the access cycle, never an error
   property p_ready_setup; psel && !penable |=> pready; endproperty
   a_ready_setup: assert property (p_ready_setup) else $error("no pready after setup");
   property p_ready_access; pready |-> psel && penable && !pslverr; endproperty
   a_ready_access: assert property (p_ready_access) else $error("pready outside access");
   // switch off keeps the line on hook
   property p_switch_gate; !modem_enable_switch [*4] |=> !$rose(off_hook); endproperty
   a_switch_gate: assert property (p_switch_gate) else $error("off hook while disabled");
   // a call names a real action slot and is a single pulse
   property p_action_valid; call_req |-> call_action inside {[3'h1:3'h4]}; endproperty
   a_action_valid: assert property (p_action_valid) else $error("call without action");
   property p_call_pulse; call_req |=> !call_req; endproperty
   a_call_pulse: assert property (p_call_pulse) else $error("call request too long");
   // timeout and correction strobes last one cycle
   property p_rtc_pulse; rtc_adjust |=> !rtc_adjust; endproperty
   a_rtc_pulse: assert property (p_rtc_pulse) else $error("clock step too long");
   property p_hang_pulse; hang_up |=> !hang_up; endproperty
   a_hang_pulse: assert property (p_hang_pulse) else $error("hang up too long");
   property p_reply_pulse; reply_timeout |=> !reply_timeout; endproperty
   a_reply_pulse: assert property (p_reply_pulse) else $error("reply flag too long");
   // monitor characters pass unchanged
   property p_pass;
      modem_char_valid |-> $past(mon_char_valid) && modem_char == $past(mon_char);
   endproperty
   a_pass: assert property (p_pass) else $error("modem char not from monitor");
   cp_call: cover property (call_req);
   cp_hook: cover property ($rose(off_hook));
   cp_rtc: cover property (rtc_adjust && rtc_adjust_up);
   cp_pass: cover property (modem_char_valid);
endmodule
bind station_link_call_sequencer station_link_call_sequencer_chk #(.TICK_CYC(TICK_CYC)) chk_i (
   .clk, .srst, .psel, .penable, .pready, .pslverr, .modem_enable_switch, .off_hook,
   .hang_up, .reply_timeout, .call_req, .call_action, .rtc_adjust, .rtc_adjust_up,
   .mon_char_valid, .mon_char, .modem_char_valid, .modem_char);
`default_nettype wire

// [modem_partner.sv]
// far side model: reports each outgoing call as reached or not reached
// assumes one call request pulse per attempt on clk
`timescale 1ns/1ps
`default_nettype none
module modem_partner (
   input wire logic clk,
   input wire logic srst,
   input wire logic call_req,
   input wire logic fail_all,
   output logic call_ok,
   output logic call_fail
);
   logic [3:0] wait_reg;
   logic busy_reg;
   logic slow_reg;
   // one result per call, alternately prompt and slow
   always_ff @(posedge clk)
   begin
      call_ok <= 1'b0;
      call_fail <= 1'b0;
      if (srst)
      begin
         busy_reg <= 1'b0;
         slow_reg <= 1'b0;
         wait_reg <= 4'h0;
      end
      else if (call_req)
      begin
         busy_reg <= 1'b1;
         wait_reg <= slow_reg ? 4'h9 : 4'h2;
         slow_reg <= !slow_reg;
      end
      else if (busy_reg && wait_reg != 4'h0)
         wait_reg <= wait_reg - 4'h1;
      else if (busy_reg)
      begin
         busy_reg <= 1'b0;
         call_ok <= !fail_all;
         call_fail <= fail_all;
      end
   end
endmodule
`default_nettype wire

// [test_station_link_call_sequencer.sv]
// self-checking bench for the station link call sequencer
// assumes the cfg header, the design, the checker and the modem model
`include "station_link_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module test_station_link_call_sequencer;
   localparam logic [31:0] CALL_V = 32'h00030102;
   logic clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata, rdata, lfsr_reg = 32'hd9f7;
   logic pready, pslverr, modem_enable_switch = 1'b1, ring_in = 1'b0, rx_char = 1'b0;
   logic tx_char = 1'b0, block_sent = 1'b0, reply_rx = 1'b0, link_up = 1'b0;
   logic fault_valid = 1'b0, call_ok, call_fail, minute_in_day_tick = 1'b0, fail_all = 1'b1;
   logic [7:0] fault_code = 8'h0, mon_char = 8'h0, modem_char;
   logic [3:0] input_event = 4'h0;
   logic [10:0] clock_minute = 11'h0;
   logic mon_char_valid = 1'b0, off_hook, hang_up, reply_timeout, call_req;
   logic rtc_adjust, rtc_adjust_up, modem_char_valid;
   logic [2:0] call_action;
   logic [1:0] level_class;
   logic [2:0] acts[$];
   int fails = 0, checked = 0, n, k, m, l, cnt, ups, t_rep;
   int rtc_v[3] = '{-2, 3, 0};
   // 40 MHz clock
   always #12.5 clk = ~clk;
   station_link_call_sequencer #(.TICK_CYC(8)) dut (.clk, .srst, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .modem_enable_switch, .ring_in, .rx_char,
      .tx_char, .block_sent, .reply_rx, .link_up, .fault_valid, .fault_code, .input_event,
      .call_ok, .call_fail, .minute_in_day_tick, .clock_minute, .mon_char_valid, .mon_char,
      .off_hook, .hang_up, .reply_timeout, .call_req, .call_action, .rtc_adjust,
      .rtc_adjust_up, .modem_char_valid, .modem_char, .level_class);
   modem_partner partner (.clk, .srst, .call_req, .fail_all, .call_ok, .call_fail);
   // record every call attempt
   always @(negedge clk)
      if (call_req === 1'b1)
         acts.push_back(call_action);
   // expectations
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [2:0] exp_act(input int i);
      return (i % 4 < 2) ? 3'h1 : 3'h2;
   endfunction
   function automatic logic [1:0] exp_lvl(input int md, input int lv);
      return md ? 2'(lv) : {1'(lv >> 1), 1'b0};
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      checked++;
      if (s !== e)
      begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // one apb transfer, held until pready
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      for (i = 0; i < 16; i++)
      begin
         @(posedge clk);
         if (pready === 1'b1)
            break;
      end
      rdata = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      if (i >= 16)
         chk("pready", 1, 0);
   endtask
   task automatic ring(input int r);
      repeat (r)
      begin
         @(posedge clk) ring_in <= 1'b1;
         repeat (4) @(posedge clk);
         ring_in <= 1'b0;
         repeat (4) @(posedge clk);
      end
   endtask
   // main sequence
   initial
   begin
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      apb(1, `SL_CALL_OFF, 32'h0);
      apb(0, `SL_CALL_OFF, 0);
      chk("locked read", 0, rdata);
      apb(1, `SL_ACCESS_OFF, `SL_ACCESS_CODE);
      apb(0, `SL_CALL_OFF, 0);
      chk("call", {12'h0, 4'h2, `SL_CYCLE_WAIT_RST, `SL_ATTEMPT_RST}, rdata);
      apb(0, `SL_MODEM_OFF, 0);
      chk("modem addr", {16'h0, `SL_MODEM_ADDR_RST}, rdata);
      apb(0, `SL_STATUS_OFF, 0);
      chk("dial mode", `SL_DIAL_PULSE, rdata[7:0]);
      apb(1, `SL_CTRL_OFF, 1);
      apb(0, `SL_STATUS_OFF, 0);
      chk("dial mode", `SL_DIAL_TONE, rdata[7:0]);
      apb(1, `SL_CMD_OFF, 32'h2);
      apb(1, `SL_CALL_OFF, CALL_V);
      apb(1, `SL_ACCESS_OFF, `SL_ACCESS_CODE);
      apb(0, `SL_CALL_OFF, 0);
      chk("after logout", {12'h0, 4'h2, `SL_CYCLE_WAIT_RST, `SL_ATTEMPT_RST}, rdata);
      apb(1, `SL_CALL_OFF, CALL_V);
      apb(1, `SL_TIMEOUT_OFF, 32'h00010205);
      // sticky fault code
      lfsr_reg = lfsr_next(lfsr_reg);
      @(posedge clk) fault_valid <= 1'b1;
      fault_code <= lfsr_reg[7:0] | 8'h01;
      @(posedge clk) fault_valid <= 1'b0;
      repeat (20) @(posedge clk);
      apb(0, `SL_ERROR_OFF, 0);
      chk("error", lfsr_reg[7:0] | 8'h01, rdata[7:0]);
      apb(1, `SL_CMD_OFF, 32'h1);
      apb(0, `SL_ERROR_OFF, 0);
      chk("error clr", `SL_ERR_CLEAR, rdata[7:0]);
      // ring count, gap timeout
      ring(2);
      repeat (4) @(negedge clk);
      chk("two rings", 0, off_hook);
      ring(1);
      for (n = 0; n < 20 && off_hook !== 1'b1; n++) @(negedge clk);
      chk("off hook", 1, off_hook);
      @(posedge clk) link_up <= 1'b1;
      rx_char <= 1'b1;
      @(posedge clk) rx_char <= 1'b0;
      for (n = 0; n < 200 && hang_up !== 1'b1; n++) @(negedge clk);
      chk("gap time", 1, n >= 41 && n <= 49);
      @(posedge clk) link_up <= 1'b0;
      // reply timeout on a second call
      ring(3);
      for (n = 0; n < 20 && off_hook !== 1'b1; n++) @(negedge clk);
      @(posedge clk) link_up <= 1'b1;
      block_sent <= 1'b1;
      rx_char <= 1'b1;
      @(posedge clk) block_sent <= 1'b0;
      rx_char <= 1'b0;
      for (n = 0; n < 40 && reply_timeout !== 1'b1; n++) @(negedge clk);
      chk("reply time", 1, n >= 6 && n <= 24);
      for (n = 0; n < 100 && hang_up !== 1'b1; n++) @(negedge clk);
      chk("call ended", 1, hang_up);
      // gap check off: only a whole idle minute ends the link
      apb(1, `SL_TIMEOUT_OFF, 32'h00010200);
      @(posedge clk) rx_char <= 1'b1;
      @(posedge clk) rx_char <= 1'b0;
      for (n = 0; n < 600 && hang_up !== 1'b1; n++) @(negedge clk);
      chk("idle time", 1, n >= 473 && n <= 481);
      @(posedge clk) link_up <= 1'b0;
      modem_enable_switch <= 1'b0;
      ring(3);
      repeat (8) @(negedge clk);
      chk("switch off", 0, off_hook);
      @(posedge clk) modem_enable_switch <= 1'b1;
      // failing call cycle, repeated once
      apb(1, `SL_INPUT_OFF, 32'h21000000);
      acts.delete();
      @(posedge clk) input_event <= 4'h1;
      @(posedge clk) input_event <= 4'h0;
      for (n = 0; n < 3000 && acts.size() < 8; n++) @(negedge clk);
      repeat (600) @(negedge clk);
      chk("calls", 8, acts.size());
      foreach (acts[i]) chk("action", exp_act(i), acts[i]);
      @(posedge clk) fail_all <= 1'b0;
      acts.delete();
      input_event <= 4'h2;
      @(posedge clk) input_event <= 4'h0;
      repeat (200) @(negedge clk);
      chk("calls ok", 1, acts.size());
      // clock correction
      foreach (rtc_v[j])
      begin
         apb(1, `SL_RTC_OFF, rtc_v[j]);
         repeat (16) @(negedge clk);
         cnt = 0;
         ups = 0;
         repeat (96)
         begin
            @(negedge clk);
            cnt += (rtc_adjust === 1'b1);
            ups += (rtc_adjust === 1'b1 && rtc_adjust_up === 1'b1);
         end
         k = rtc_v[j] ? 12 / (rtc_v[j] < 0 ? -rtc_v[j] : rtc_v[j]) : 0;
         chk("rtc steps", 1, cnt + 1 >= k && cnt <= k + (k > 0));
         chk("rtc dir", rtc_v[j] > 0 ? cnt : 0, ups);
      end
      // level classes in both modes
      for (m = 0; m < 2; m++)
         for (l = 0; l < 4; l++)
         begin
            apb(1, `SL_CTRL_OFF, m << 1);
            apb(1, `SL_INPUT_OFF, 32'h21000000 | l);
            repeat (3) @(negedge clk);
            chk("level", exp_lvl(m, l), level_class);
         end
      // monitor pass-through
      apb(1, `SL_CTRL_OFF, 32'h4);
      repeat (4)
      begin
         lfsr_reg = lfsr_next(lfsr_reg);
         @(posedge clk) mon_char_valid <= 1'b1;
         mon_char <= lfsr_reg[7:0];
         @(posedge clk) mon_char_valid <= 1'b0;
         for (n = 0; n < 8 && modem_char_valid !== 1'b1; n++) @(negedge clk);
         chk("pass char", {1'b1, lfsr_reg[7:0]}, {modem_char_valid, modem_char});
      end
      // logged out: reads need the station password
      apb(1, `SL_PWSET_OFF, 32'h10000abc);
      apb(1, `SL_CMD_OFF, 32'h2);
      @(posedge clk) link_up <= 1'b1;
      for (m = 0; m < 2; m++)
      begin
         apb(1, `SL_PWCHK_OFF, 32'h10000abd - m);
         apb(0, `SL_CALL_OFF, 0);
         chk("password", m ? CALL_V : 0, rdata);
      end
      tally_and_finish();
   end
endmodule
`default_nettype wire
